/* File: core/uifc_pkg.sv */
// Purpose: Shared constants of the channel interrupt and queue control.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Status codes are six bits, bit 0 low while a source is pending.
package uifc_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFF_MASK = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_QCTRL = 8'h08;
   localparam logic [7:0] OFF_TABLE = 8'h0c;
   // Reset values.
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [1:0] TABLE_RST = 2'h0;
   localparam logic [1:0] SEL_RST = 2'h0;
   // Mask register bit positions.
   localparam int M_RXD = 0;
   localparam int M_TXR = 1;
   localparam int M_LINE = 2;
   localparam int M_MODEM = 3;
   localparam int M_SLEEP = 4;
   localparam int M_XOFF = 5;
   localparam int M_RTS = 6;
   localparam int M_CTS = 7;
   // Queue control bit positions.
   localparam int QC_EN = 0;
   localparam int QC_RXCLR = 1;
   localparam int QC_TXCLR = 2;
   localparam int QC_DMA = 3;
   localparam int QC_TXSEL = 4;
   localparam int QC_RXSEL = 6;
   // Status codes by priority.
   localparam logic [5:0] CODE_LINE = 6'h06;
   localparam logic [5:0] CODE_TOUT = 6'h0c;
   localparam logic [5:0] CODE_RXD = 6'h04;
   localparam logic [5:0] CODE_TXR = 6'h02;
   localparam logic [5:0] CODE_MODEM = 6'h00;
   localparam logic [5:0] CODE_XOFF = 6'h10;
   localparam logic [5:0] CODE_FLOW = 6'h20;
   localparam logic [5:0] CODE_NONE = 6'h01;
   // Receive time-out in character times and bit times.
   localparam logic [7:0] TOUT_CHARS = 8'h04;
   localparam logic [7:0] TOUT_BITS = 8'h0c;
   // Fixed trigger tables, four levels packed low byte first.
   localparam logic [31:0] TRIG_A_RX = 32'h0e080401;
   localparam logic [31:0] TRIG_A_TX = 32'h01010101;
   localparam logic [31:0] TRIG_B_RX = 32'h1c181008;
   localparam logic [31:0] TRIG_B_TX = 32'h1e180810;
   localparam logic [31:0] TRIG_C_RX = 32'h3c381008;
   localparam logic [31:0] TRIG_C_TX = 32'h38201008;
   localparam logic [1:0] TABLE_PROG = 2'h3;
endpackage

/* File: core/uifc_core.sv */
// Purpose: Interrupt mask, prioritised source status and queue control.
// Assumes: UART datapath inputs share pclk; only the CTS pin is async.
// Notes: APB answers one cycle into the access phase.
//
// Summary of operation
// - Receive data source: holding full, or receive level at trigger.
// - Transmit ready on empty or below trigger, also when enabled.
// - Line status error bits raise a source as the character lands.
// - Mask bits 7 to 4 act only while the unlock bit is set.
// - RTS or CTS rising edge raises a source under auto flow.
// - Status read returns highest pending source; others stay queued.
// - Time-out after four characters plus twelve bits below trigger.
// - Transmit ready from trigger or empty; RS-485 uses fully empty while the queue is enabled.
// - Received Xoff or special character raises its source.
// - Line status read clears the line source.
// - Receive data clears below trigger; time-out clears on data read.
// - Transmit ready clears on status read or transmit write.
// - Modem status read clears modem, RTS and CTS sources.
// - Xoff clears on status read or Xon; special on next character.
// - Status bits 5:0 carry the priority code of the source.
// - Status bit 0 is low while pending, high otherwise.
// - Status bits 7:6 follow the queue enable.
// - Queue control write with bit 0 low ignores the other bits.
// - Bits 1 and 2 clear the queues for one cycle only.
// - Bit 3 selects DMA behaviour of the ready pins.
// - Transmit trigger bits need unlock; empty case after small reload.
// - Receive and transmit share the one trigger table selection.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module uifc_core #(
   parameter logic [7:0] FIFO_DEPTH = 8'h80
) (
   // Clock, reset and enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receive side of the datapath.
   input wire logic [7:0] rx_level,
   input wire logic rx_char,
   input wire logic rx_read,
   input wire logic bit_tick,
   input wire logic [3:0] char_bits,
   input wire logic [3:0] line_err,
   input wire logic line_read,
   input wire logic xoff_seen,
   input wire logic xon_seen,
   input wire logic special_seen,
   // Transmit side of the datapath.
   input wire logic [7:0] tx_level,
   input wire logic thr_empty,
   input wire logic tx_all_empty,
   input wire logic tx_write,
   input wire logic rs485_auto,
   // Modem and flow control.
   input wire logic [3:0] modem_delta,
   input wire logic modem_read,
   input wire logic unlock,
   input wire logic auto_rts,
   input wire logic auto_cts,
   input wire logic rts_pin_n,
   input wire logic cts_pin_n,
   // Programmable trigger levels of the fourth table.
   input wire logic [7:0] rx_prog_trig,
   input wire logic [7:0] tx_prog_trig,
   // Control outputs.
   output logic int_req,
   output logic sleep_en,
   output logic fifo_en,
   output logic dma_mode,
   output logic rx_fifo_clr,
   output logic tx_fifo_clr,
   output logic [7:0] rx_trig,
   output logic [7:0] tx_trig,
   output logic receive_ready_pin_n,
   output logic transmit_ready_pin_n
);

   ////////////////////////////////////////////////////////////////////////
   // Trigger table lookup.
   function automatic logic [7:0] trig_lvl(input logic [1:0] tbl,
                                           input logic [1:0] sel,
                                           input logic tx);
      logic [31:0] lut;
      lut = 32'h0;
      case (tbl)
         2'h0: lut = tx ? uifc_pkg::TRIG_A_TX : uifc_pkg::TRIG_A_RX;
         2'h1: lut = tx ? uifc_pkg::TRIG_B_TX : uifc_pkg::TRIG_B_RX;
         2'h2: lut = tx ? uifc_pkg::TRIG_C_TX : uifc_pkg::TRIG_C_RX;
         default: lut = 32'h0;
      endcase
      return lut[{sel, 3'h0} +: 8];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State.
   logic rdy_reg, rdy_next, err_reg, err_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [5:0] rdcode_reg, rdcode_next;
   logic [7:0] mask_reg, mask_next;
   logic fen_reg, fen_next, dma_reg, dma_next;
   logic [1:0] rxsel_reg, rxsel_next, txsel_reg, txsel_next;
   logic [1:0] table_reg, table_next;
   logic rxclr_reg, rxclr_next, txclr_reg, txclr_next;
   logic line_p, line_pn, tout_p, tout_pn, tx_p, tx_pn;
   logic modem_p, modem_pn, xoff_p, xoff_pn, spec_p, spec_pn;
   logic rts_p, rts_pn, cts_p, cts_pn;
   logic reload_reg, reload_next, txc_prev, txc_prev_next;
   logic line_prev, modem_prev, rts_prev, cts_prev;
   logic cts_s1, cts_s2;
   logic [7:0] tmr_reg, tmr_next;
   logic int_reg, int_next, rxpin_reg, rxpin_next, txpin_reg, txpin_next;

   // Combinational terms.
   logic access, done, wr, rd;
   logic [7:0] en, lim;
   logic rxd_cond, tx_cond, armed, tx_set, tout_set;
   logic line_set, rts_set, cts_set, any_src, isr_rd;
   logic s_line, s_tout, s_rxd, s_tx, s_mod, s_xoff, s_flow;
   logic [5:0] cur_code;

   assign pready = rdy_reg;
   assign prdata = rdata_reg;
   assign pslverr = err_reg;
   assign int_req = int_reg;
   assign sleep_en = mask_reg[uifc_pkg::M_SLEEP] & unlock;
   assign fifo_en = fen_reg;
   assign dma_mode = dma_reg;
   assign rx_fifo_clr = rxclr_reg;
   assign tx_fifo_clr = txclr_reg;
   assign receive_ready_pin_n = rxpin_reg;
   assign transmit_ready_pin_n = txpin_reg;

   ////////////////////////////////////////////////////////////////////////
   // Source conditions and priority.
   always_comb begin
      en = {mask_reg[7:4] & {4{unlock}}, mask_reg[3:0]};
      rx_trig = (table_reg == uifc_pkg::TABLE_PROG) ? rx_prog_trig :
                trig_lvl(table_reg, rxsel_reg, 1'b0);
      tx_trig = (table_reg == uifc_pkg::TABLE_PROG) ? tx_prog_trig :
                trig_lvl(table_reg, txsel_reg, 1'b1);
      rxd_cond = fen_reg ? (rx_level >= rx_trig) :
                 (rx_level != 8'h00);
      if (!fen_reg) begin
         tx_cond = thr_empty;
      end else if (rs485_auto) begin
         tx_cond = tx_all_empty;
      end else begin
         tx_cond = reload_reg ? (tx_level < tx_trig) :
                   (tx_level == 8'h00);
      end
      armed = fen_reg && (rx_level != 8'h00) && (rx_level < rx_trig);
      lim = uifc_pkg::TOUT_CHARS * {4'h0, char_bits} +
            uifc_pkg::TOUT_BITS;
      tout_set = armed && (tmr_reg == lim) && !rx_char && !rx_read;
      tx_set = (tx_cond && !txc_prev) ||
               (tx_cond && mask_next[uifc_pkg::M_TXR] &&
                !mask_reg[uifc_pkg::M_TXR]);
      line_set = (|line_err) && !line_prev;
      rts_set = rts_pin_n && !rts_prev && auto_rts;
      cts_set = cts_s2 && !cts_prev && auto_cts;
      s_line = line_p & en[uifc_pkg::M_LINE];
      s_tout = tout_p & en[uifc_pkg::M_RXD];
      s_rxd = rxd_cond & en[uifc_pkg::M_RXD];
      s_tx = tx_p & en[uifc_pkg::M_TXR];
      s_mod = modem_p & en[uifc_pkg::M_MODEM];
      s_xoff = (xoff_p | spec_p) & en[uifc_pkg::M_XOFF];
      s_flow = (rts_p & en[uifc_pkg::M_RTS]) | (cts_p & en[uifc_pkg::M_CTS]);
      any_src = s_line | s_tout | s_rxd | s_tx | s_mod | s_xoff | s_flow;
      if (s_line) begin
         cur_code = uifc_pkg::CODE_LINE;
      end else if (s_tout) begin
         cur_code = uifc_pkg::CODE_TOUT;
      end else if (s_rxd) begin
         cur_code = uifc_pkg::CODE_RXD;
      end else if (s_tx) begin
         cur_code = uifc_pkg::CODE_TXR;
      end else if (s_mod) begin
         cur_code = uifc_pkg::CODE_MODEM;
      end else if (s_xoff) begin
         cur_code = uifc_pkg::CODE_XOFF;
      end else if (s_flow) begin
         cur_code = uifc_pkg::CODE_FLOW;
      end else begin
         cur_code = uifc_pkg::CODE_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave and registers.
   always_comb begin
      access = psel & penable;
      done = access & rdy_reg;
      wr = done & pwrite;
      rd = done & ~pwrite;
      rdy_next = access & ~rdy_reg;
      rdata_next = rdata_reg;
      err_next = 1'b0;
      rdcode_next = rdcode_reg;
      mask_next = mask_reg;
      fen_next = fen_reg;
      dma_next = dma_reg;
      rxsel_next = rxsel_reg;
      txsel_next = txsel_reg;
      table_next = table_reg;
      rxclr_next = 1'b0;
      txclr_next = 1'b0;
      if (rdy_next) begin
         rdata_next = 32'h0;
         if (paddr == uifc_pkg::OFF_MASK) begin
            rdata_next[7:0] = mask_reg;
         end else if (paddr == uifc_pkg::OFF_STATUS) begin
            rdata_next[7:0] = {{2{fen_reg}}, cur_code};
            rdcode_next = cur_code;
         end else if (paddr == uifc_pkg::OFF_QCTRL) begin
            rdata_next = 32'h0;
         end else if (paddr == uifc_pkg::OFF_TABLE) begin
            rdata_next[1:0] = table_reg;
         end else begin
            err_next = 1'b1;
         end
      end
      isr_rd = rd && (paddr == uifc_pkg::OFF_STATUS);
      if (wr && paddr == uifc_pkg::OFF_MASK) begin
         mask_next = pwdata[7:0];
      end else if (wr && paddr == uifc_pkg::OFF_QCTRL) begin
         fen_next = pwdata[uifc_pkg::QC_EN];
         if (pwdata[uifc_pkg::QC_EN]) begin
            rxclr_next = pwdata[uifc_pkg::QC_RXCLR];
            txclr_next = pwdata[uifc_pkg::QC_TXCLR];
            dma_next = pwdata[uifc_pkg::QC_DMA];
            rxsel_next = pwdata[uifc_pkg::QC_RXSEL +: 2];
            if (unlock) begin
               txsel_next = pwdata[uifc_pkg::QC_TXSEL +: 2];
            end
         end
      end else if (wr && paddr == uifc_pkg::OFF_TABLE) begin
         table_next = pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending sources, timer and pins.
   always_comb begin
      line_pn = line_set | (line_p & ~line_read);
      tout_pn = tout_set | (tout_p & ~rx_read & armed);
      tx_pn = tx_set | (tx_p & ~tx_write &
              ~(isr_rd && rdcode_reg == uifc_pkg::CODE_TXR));
      modem_pn = ((|modem_delta) & ~modem_prev) |
                 (modem_p & ~modem_read);
      xoff_pn = xoff_seen | (xoff_p & ~xon_seen &
                ~(isr_rd && rdcode_reg == uifc_pkg::CODE_XOFF));
      spec_pn = special_seen | (spec_p & ~rx_char &
                ~(isr_rd && rdcode_reg == uifc_pkg::CODE_XOFF));
      rts_pn = rts_set | (rts_p & ~modem_read);
      cts_pn = cts_set | (cts_p & ~modem_read);
      reload_next = reload_reg;
      if (tx_level > tx_trig) begin
         reload_next = 1'b1;
      end else if (tx_level == 8'h00) begin
         reload_next = 1'b0;
      end
      txc_prev_next = tx_cond;
      tmr_next = tmr_reg;
      if (!armed || rx_char || rx_read) begin
         tmr_next = 8'h00;
      end else if (bit_tick && tmr_reg != lim) begin
         tmr_next = tmr_reg + 8'h01;
      end
      int_next = any_src;
      rxpin_next = dma_reg ? ~(rxd_cond | tout_p) : (rx_level == 8'h00);
      txpin_next = dma_reg ? (tx_level >= FIFO_DEPTH) :
                   ~((tx_level == 8'h00) & thr_empty);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_reg <= 1'b0;
         err_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rdcode_reg <= uifc_pkg::CODE_NONE;
         mask_reg <= uifc_pkg::MASK_RST;
         fen_reg <= 1'b0;
         dma_reg <= 1'b0;
         rxsel_reg <= uifc_pkg::SEL_RST;
         txsel_reg <= uifc_pkg::SEL_RST;
         table_reg <= uifc_pkg::TABLE_RST;
         rxclr_reg <= 1'b0;
         txclr_reg <= 1'b0;
         line_p <= 1'b0;
         tout_p <= 1'b0;
         tx_p <= 1'b0;
         modem_p <= 1'b0;
         xoff_p <= 1'b0;
         spec_p <= 1'b0;
         rts_p <= 1'b0;
         cts_p <= 1'b0;
         reload_reg <= 1'b0;
         txc_prev <= 1'b0;
         line_prev <= 1'b0;
         modem_prev <= 1'b0;
         rts_prev <= 1'b0;
         cts_prev <= 1'b0;
         cts_s1 <= 1'b0;
         cts_s2 <= 1'b0;
         tmr_reg <= 8'h00;
         int_reg <= 1'b0;
         rxpin_reg <= 1'b1;
         txpin_reg <= 1'b1;
      end else if (ce) begin
         rdy_reg <= rdy_next;
         err_reg <= err_next;
         rdata_reg <= rdata_next;
         rdcode_reg <= rdcode_next;
         mask_reg <= mask_next;
         fen_reg <= fen_next;
         dma_reg <= dma_next;
         rxsel_reg <= rxsel_next;
         txsel_reg <= txsel_next;
         table_reg <= table_next;
         rxclr_reg <= rxclr_next;
         txclr_reg <= txclr_next;
         line_p <= line_pn;
         tout_p <= tout_pn;
         tx_p <= tx_pn;
         modem_p <= modem_pn;
         xoff_p <= xoff_pn;
         spec_p <= spec_pn;
         rts_p <= rts_pn;
         cts_p <= cts_pn;
         reload_reg <= reload_next;
         txc_prev <= txc_prev_next;
         line_prev <= |line_err;
         modem_prev <= |modem_delta;
         rts_prev <= rts_pin_n;
         cts_prev <= cts_s2;
         cts_s1 <= cts_pin_n;
         cts_s2 <= cts_s1;
         tmr_reg <= tmr_next;
         int_reg <= int_next;
         rxpin_reg <= rxpin_next;
         txpin_reg <= txpin_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   pend_flag_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && rdy_next && paddr == uifc_pkg::OFF_STATUS
      |=> prdata[0] == !$past(any_src))
      else $error("Status bit 0 disagrees with pending sources.");
   fifo_bits_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && rdy_next && paddr == uifc_pkg::OFF_STATUS
      |=> prdata[7:6] == {2{fen_reg}})
      else $error("Status bits 7:6 disagree with queue enable.");
   tx_clear_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && tx_write && !tx_set |=> !tx_p)
      else $error("Transmit write left transmit source pending.");
   flow_clear_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && modem_read && !rts_set && !cts_set |=> !rts_p && !cts_p)
      else $error("Modem read left flow sources pending.");
   tout_clear_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && rx_read && !tout_set |=> !tout_p)
      else $error("Data read left time-out pending.");
   clr_pulse_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && rxclr_reg |=> !rxclr_reg)
      else $error("Receive clear lasted over one cycle.");
   fifo_off_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && wr && paddr == uifc_pkg::OFF_QCTRL && !pwdata[0]
      |=> !fen_reg && dma_reg == $past(dma_reg) && !rxclr_reg)
      else $error("Disabled queue write changed other bits.");
   lock_mask_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !unlock |-> !s_xoff && !s_flow && !sleep_en)
      else $error("Locked mask bits took effect.");
   line_first_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && line_set && en[uifc_pkg::M_LINE] && !line_read
      |=> cur_code == uifc_pkg::CODE_LINE)
      else $error("Line source not reported first.");
endmodule

/* File: tb/uifc_host.sv */
// Purpose: Host model that reaches the channel registers over APB.
// Assumes: Requests start only after reset is released.
// Notes: Waits for pready without limit; the bench watchdog ends a hang.
`timescale 1ns/1ps
module uifc_host (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB master side.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
////////////////////////////////////////////////////////////////////////////
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
////////////////////////////////////////////////////////////////////////////
   // One transfer: setup, then access held until pready is sampled high.
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      wait (presetn === 1'b1);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

/* File: tb/uart_interrupt_fifo_control_bench.sv */
// Purpose: Self-checking bench of the channel interrupt and queue control.
// Assumes: Datapath events are one-cycle pulses on ev, driven at pclk.
// Notes: Status values include bits 7:6, which follow the queue enable.
`timescale 1ns/1ps
module uart_interrupt_fifo_control_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr, rx_trig, tx_trig;
   logic [31:0] pwdata, prdata, q;
   // Events: 0 rx_char 1 rx_read 2 bit_tick 3 line_read 4 xoff 5 xon
   // 6 special 7 modem_read 8 tx_write.
   logic [8:0] ev = 9'h0;
   logic [7:0] rx_level = 8'h00;
   logic [7:0] tx_level = 8'h00;
   logic [3:0] char_bits = 4'h5;
   logic [3:0] line_err = 4'h0;
   logic [3:0] modem_delta = 4'h0;
   logic thr_empty = 1'b1, tx_all_empty = 1'b1, unlock = 1'b0;
   logic auto_rts = 1'b0, auto_cts = 1'b0, rs485 = 1'b0;
   logic rts_pin_n = 1'b0, cts_pin_n = 1'b0;
   logic int_req, sleep_en, fifo_en, dma_mode, rx_fifo_clr, tx_fifo_clr;
   logic rx_pin_n, tx_pin_n;
   int error_cnt = 0, comparisons = 0, cyc = 0, nrx = 0, ntx = 0;
////////////////////////////////////////////////////////////////////////////
   always #12.5 pclk = ~pclk;
   uifc_host HOST (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   uifc_core DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_level(rx_level), .rx_char(ev[0]), .rx_read(ev[1]),
      .bit_tick(ev[2]), .char_bits(char_bits), .line_err(line_err),
      .line_read(ev[3]), .xoff_seen(ev[4]), .xon_seen(ev[5]),
      .special_seen(ev[6]), .tx_level(tx_level), .thr_empty(thr_empty),
      .tx_all_empty(tx_all_empty), .tx_write(ev[8]), .rs485_auto(rs485),
      .modem_delta(modem_delta), .modem_read(ev[7]), .unlock(unlock),
      .auto_rts(auto_rts), .auto_cts(auto_cts), .rts_pin_n(rts_pin_n),
      .cts_pin_n(cts_pin_n), .rx_prog_trig(8'h20), .tx_prog_trig(8'h03),
      .int_req(int_req), .sleep_en(sleep_en), .fifo_en(fifo_en),
      .dma_mode(dma_mode), .rx_fifo_clr(rx_fifo_clr),
      .tx_fifo_clr(tx_fifo_clr), .rx_trig(rx_trig), .tx_trig(tx_trig),
      .receive_ready_pin_n(rx_pin_n), .transmit_ready_pin_n(tx_pin_n));
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (rx_fifo_clr === 1'b1) nrx <= nrx + 1;
      if (tx_fifo_clr === 1'b1) ntx <= ntx + 1;
      if (cyc == 5000) begin
         error_cnt++;
         results();
      end
   end
////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e,
         input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      HOST.xfer(1'b0, a, 32'h0, q, er);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      HOST.xfer(1'b1, a, {24'h0, d}, q, er);
   endtask
   task automatic st(input logic [7:0] e);
      rd(uifc_pkg::OFF_STATUS);
      chk("status", e, q[7:0]);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic pulse(input int i);
      @(posedge pclk);
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev[i] <= 1'b0;
      tick(2);
   endtask
////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      st(8'h01);
      rd(uifc_pkg::OFF_MASK);
      chk("mask", 8'h00, q[7:0]);
      rd(uifc_pkg::OFF_QCTRL);
      chk("qctrl", 8'h00, q[7:0]);
      rd(8'h10);
      chk("slverr", 8'h01, {7'h0, er});
      chk("unmapped", 8'h00, q[7:0]);
      wr(uifc_pkg::OFF_MASK, 8'hf5);
      rd(uifc_pkg::OFF_MASK);
      chk("mask", 8'hf5, q[7:0]);
      chk("int_req", 8'h00, {7'h0, int_req});
   endtask
   task automatic t_qctrl;
      wr(uifc_pkg::OFF_QCTRL, 8'h0e);
      tick(2);
      chk("clr", 8'h00, 8'(nrx + ntx));
      st(8'h01);
      wr(uifc_pkg::OFF_QCTRL, 8'h0f);
      tick(2);
      chk("rx_clr", 8'h01, 8'(nrx));
      chk("tx_clr", 8'h01, 8'(ntx));
      chk("dma", 8'h01, {7'h0, dma_mode});
      chk("fifo_en", 8'h01, {7'h0, fifo_en});
      st(8'hc1);
      wr(uifc_pkg::OFF_QCTRL, 8'h01);
      tick(2);
      chk("dma", 8'h00, {7'h0, dma_mode});
   endtask
   task automatic t_prio;
      wr(uifc_pkg::OFF_MASK, 8'h0f);
      tick(3);
      chk("int_req", 8'h01, {7'h0, int_req});
      thr_empty <= 1'b0;
      tx_level <= 8'h05;
      tx_all_empty <= 1'b0;
      tick(2);
      st(8'hc2);
      st(8'hc1);
      line_err <= 4'h2;
      rx_level <= 8'h02;
      modem_delta <= 4'h1;
      tx_level <= 8'h00;
      tick(4);
      chk("rx_pin", 8'h00, {7'h0, rx_pin_n});
      chk("tx_pin", 8'h01, {7'h0, tx_pin_n});
      st(8'hc6);
      st(8'hc6);
      pulse(3);
      st(8'hc4);
      rx_level <= 8'h00;
      tick(3);
      tx_level <= 8'h05;
      st(8'hc2);
      st(8'hc0);
      line_err <= 4'h0;
      modem_delta <= 4'h0;
      pulse(7);
      st(8'hc1);
      chk("int_req", 8'h00, {7'h0, int_req});
   endtask
   task automatic t_xoff;
      wr(uifc_pkg::OFF_MASK, 8'h20);
      pulse(4);
      st(8'hc1);
      pulse(5);
      unlock <= 1'b1;
      tick(3);
      st(8'hc1);
      pulse(4);
      st(8'hd0);
      pulse(4);
      pulse(5);
      st(8'hc1);
      pulse(6);
      st(8'hd0);
      pulse(6);
      pulse(0);
      st(8'hc1);
      pulse(4);
      st(8'hd0);
      st(8'hc1);
   endtask
   task automatic t_flow;
      auto_cts <= 1'b1;
      auto_rts <= 1'b1;
      wr(uifc_pkg::OFF_MASK, 8'hd0);
      tick(1);
      chk("sleep", 8'h01, {7'h0, sleep_en});
      cts_pin_n <= 1'b1;
      tick(5);
      st(8'he0);
      pulse(7);
      st(8'hc1);
      rts_pin_n <= 1'b1;
      tick(3);
      st(8'he0);
      pulse(7);
      st(8'hc1);
      auto_cts <= 1'b0;
      cts_pin_n <= 1'b0;
      tick(4);
      cts_pin_n <= 1'b1;
      tick(5);
      st(8'hc1);
   endtask
   task automatic t_tout;
      wr(uifc_pkg::OFF_MASK, 8'h01);
      wr(uifc_pkg::OFF_QCTRL, 8'h41);
      tick(1);
      chk("rx_trig", 8'h04, rx_trig);
      char_bits <= 4'h8;
      rx_level <= 8'h02;
      repeat (43) pulse(2);
      st(8'hc1);
      pulse(2);
      st(8'hcc);
      pulse(1);
      st(8'hc1);
      rx_level <= 8'h00;
   endtask
   task automatic t_table;
      wr(uifc_pkg::OFF_TABLE, 8'h01);
      tick(1);
      chk("rx_trig", 8'h10, rx_trig);
      chk("tx_trig", 8'h10, tx_trig);
      unlock <= 1'b0;
      wr(uifc_pkg::OFF_QCTRL, 8'h51);
      tick(1);
      chk("tx_trig", 8'h10, tx_trig);
      unlock <= 1'b1;
      wr(uifc_pkg::OFF_QCTRL, 8'h51);
      tick(1);
      chk("tx_trig", 8'h08, tx_trig);
      rd(uifc_pkg::OFF_TABLE);
      chk("table", 8'h01, q[7:0]);
      wr(uifc_pkg::OFF_TABLE, 8'h03);
      tick(1);
      chk("rx_trig", 8'h20, rx_trig);
      chk("tx_trig", 8'h03, tx_trig);
      rs485 <= 1'b1;
      wr(uifc_pkg::OFF_MASK, 8'h02);
      st(8'hc2);
      tick(2);
      st(8'hc1);
      tx_all_empty <= 1'b1;
      tick(3);
      st(8'hc2);
      wr(uifc_pkg::OFF_MASK, 8'h00);
      wr(uifc_pkg::OFF_MASK, 8'h02);
      st(8'hc2);
   endtask
////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_qctrl();
      t_prio();
      t_xoff();
      t_flow();
      t_tout();
      t_table();
      results();
   end
endmodule
